// [core/acmp_ctrl.v]
// Control, status, interrupt and pin-sharing logic around an analog comparator
//
// How it works
// RULE1: Enable bit 6 powers comparator; when clear the output bit reads low.
// RULE2: Polarity bit 5 clear passes raw result, set inverts it.
// RULE3: Output bit 4 is read-only, high when plus input wins (polarity 0).
// RULE4: Bit 0 enables hysteresis and resets to one.
// RULE5: Bits 7 and 3 to 1 read zero and ignore writes.
// RULE6: Every output-bit change sets the flag; enabled flag raises interrupt.
// RULE7: In sleep or idle with comparator on, a change also requests wake-up.
// RULE8: Software pre-sets the flag before sleep to suppress that wake-up.
// RULE9: Low-power mode never disables comparator, output or interrupt logic.
// RULE10: Software clears the enable bit when unused, to save power.
// RULE11: Comparator pins read zero when control bit set, else port data; code does this only while bit 6 is set.
// RULE12: Output bit may drive a shared pin selected for comparator output.
// RULE13: Raw analog result passes a two-flop synchroniser before use.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "acmp_regs.vh"

module acmp_ctrl
(
    input wire mclk,
    input wire rstn,
    input wire [`ACMP_ADDR_W-1:0] regAddr,
    input wire [`ACMP_DATA_W-1:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [`ACMP_DATA_W-1:0] regRdata,
    input wire cmpRaw,
    output wire cmpPower,
    output wire hystEnable,
    input wire lowPower,
    output wire irq,
    output reg wakeReq,
    input wire [`ACMP_PIN_N-1:0] pinIn,
    output reg [`ACMP_PIN_N-1:0] pinOut,
    output reg [`ACMP_PIN_N-1:0] pinOe
);

////////////////////////////////////////////////////////////////////////////////
// State

reg compareOn;
reg outputInvert;
reg hysteresisOn;
reg compareResult;
reg [`ACMP_INT_N-1:0] intStatus;
reg [`ACMP_INT_N-1:0] intMask;
reg [`ACMP_PIN_N-1:0] portData;
reg [`ACMP_PIN_N-1:0] portCtrl;
reg [`ACMP_PIN_N-1:0] pinFunc;

wire rawSync;
wire wrCtrl;
wire wrStatus;
wire wrMask;
wire wrSet;
wire wrPortData;
wire wrPortCtrl;
wire wrPinFunc;
wire next_compareResult;
wire resultChange;
wire wakeEvent;
wire [`ACMP_INT_N-1:0] intHwSet;
wire [`ACMP_INT_N-1:0] intSwSet;
wire [`ACMP_INT_N-1:0] intSwClr;
wire [`ACMP_INT_N-1:0] next_intStatus;
wire [`ACMP_PIN_N-1:0] portRead;
wire [`ACMP_DATA_W-1:0] ctrlRead;

reg [`ACMP_DATA_W-1:0] next_regRdata;

////////////////////////////////////////////////////////////////////////////////
// Synchroniser

acmp_sync uSync
(
    .mclk(mclk),
    .rstn(rstn),
    .asyncIn(cmpRaw),
    .syncOut(rawSync)
); // RULE13

////////////////////////////////////////////////////////////////////////////////
// Write decode

assign wrCtrl = regWr && (regAddr == `ACMP_OFF_CTRL);
assign wrStatus = regWr && (regAddr == `ACMP_OFF_INT_STATUS);
assign wrMask = regWr && (regAddr == `ACMP_OFF_INT_MASK);
assign wrSet = regWr && (regAddr == `ACMP_OFF_INT_SET);
assign wrPortData = regWr && (regAddr == `ACMP_OFF_PORT_DATA);
assign wrPortCtrl = regWr && (regAddr == `ACMP_OFF_PORT_CTRL);
assign wrPinFunc = regWr && (regAddr == `ACMP_OFF_PIN_FUNC);

////////////////////////////////////////////////////////////////////////////////
// Control register

// Only the writable fields are stored; bit 4 reads back the output bit and the rest read back zero
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        compareOn <= `ACMP_RST_ON;
        outputInvert <= `ACMP_RST_INVERT;
        hysteresisOn <= `ACMP_RST_HYST; // RULE4
    end
    else if (wrCtrl)
    begin
        compareOn <= regWdata[`ACMP_BIT_ON]; // RULE1
        outputInvert <= regWdata[`ACMP_BIT_INVERT]; // RULE2
        hysteresisOn <= regWdata[`ACMP_BIT_HYST]; // RULE4
    end
end

// Analog controls do not look at lowPower: sleep leaves them alone
assign cmpPower = compareOn; // RULE1 RULE9
assign hystEnable = hysteresisOn; // RULE4

////////////////////////////////////////////////////////////////////////////////
// Output bit

// Forced low while off, so a stale raw level cannot leak through
assign next_compareResult = compareOn & (rawSync ^ outputInvert); // RULE1 RULE2 RULE3

always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        compareResult <= `ACMP_RST_RESULT;
    end
    else
    begin
        compareResult <= next_compareResult; // RULE3
    end
end

// Any edge counts, including one caused by toggling polarity or enable
assign resultChange = next_compareResult ^ compareResult; // RULE6

////////////////////////////////////////////////////////////////////////////////
// Interrupt status and mask

// Wake only on a 0 to 1 flag transition, so a pre-set flag blocks it
assign wakeEvent = lowPower & compareOn & resultChange
                   & ~intStatus[`ACMP_INT_CHANGE]; // RULE7 RULE8

assign intHwSet[`ACMP_INT_CHANGE] = resultChange; // RULE6
assign intHwSet[`ACMP_INT_WAKE] = wakeEvent; // RULE7
assign intSwSet = wrSet ? regWdata[`ACMP_INT_N-1:0] : {`ACMP_INT_N{1'b0}};
assign intSwClr = wrStatus ? regWdata[`ACMP_INT_N-1:0] : {`ACMP_INT_N{1'b0}};

// Set beats a same-cycle write-one-to-clear
assign next_intStatus = (intStatus & ~intSwClr) | intHwSet | intSwSet; // RULE6

always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        intStatus <= `ACMP_RST_INT;
        intMask <= `ACMP_RST_INT;
    end
    else
    begin
        intStatus <= next_intStatus;
        if (wrMask)
        begin
            intMask <= regWdata[`ACMP_INT_N-1:0];
        end
    end
end

// Mask bit of the change flag acts as the interrupt enable
assign irq = |(intStatus & intMask); // RULE6

// Wake request is a one-cycle pulse to the power manager
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        wakeReq <= 1'b0;
    end
    else
    begin
        wakeReq <= wakeEvent; // RULE7 RULE9
    end
end

////////////////////////////////////////////////////////////////////////////////
// Shared pins

always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        portData <= `ACMP_RST_PINS;
        portCtrl <= `ACMP_RST_PINS;
        pinFunc <= `ACMP_RST_PINS;
    end
    else
    begin
        if (wrPortData)
        begin
            portData <= regWdata[`ACMP_PIN_N-1:0];
        end
        if (wrPortCtrl)
        begin
            portCtrl <= regWdata[`ACMP_PIN_N-1:0];
        end
        if (wrPinFunc)
        begin
            pinFunc <= regWdata[`ACMP_PIN_N-1:0];
        end
    end
end

genvar gi;
generate
    for (gi = 0; gi < `ACMP_PIN_N; gi = gi + 1)
    begin : gPin
        wire cmpPin;
        assign cmpPin = pinFunc[gi] & compareOn;
        // Analog pins never see a digital level in read-back while the comparator is on
        assign portRead[gi] = cmpPin ? (portCtrl[gi] ? 1'b0 : portData[gi])
                                     : (portCtrl[gi] ? pinIn[gi] : portData[gi]); // RULE11

        always @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
            begin
                pinOut[gi] <= 1'b0;
                pinOe[gi] <= 1'b0;
            end
            else if (pinFunc[gi])
            begin
                if (gi == `ACMP_PIN_OUT)
                begin
                    pinOut[gi] <= compareResult; // RULE12
                    pinOe[gi] <= 1'b1; // RULE12
                end
                else
                begin
                    // Input pins float so the analog level is undisturbed
                    pinOut[gi] <= 1'b0;
                    pinOe[gi] <= 1'b0;
                end
            end
            else
            begin
                pinOut[gi] <= portData[gi];
                pinOe[gi] <= ~portCtrl[gi];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read path

assign ctrlRead = {1'b0, compareOn, outputInvert, compareResult,
                   3'h0, hysteresisOn}; // RULE5

always @*
begin
    next_regRdata = 8'h00;
    case (regAddr)
        `ACMP_OFF_CTRL:
        begin
            next_regRdata = ctrlRead; // RULE3 RULE5
        end
        `ACMP_OFF_INT_STATUS:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_INT_N){1'b0}}, intStatus};
        end
        `ACMP_OFF_INT_MASK:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_INT_N){1'b0}}, intMask};
        end
        `ACMP_OFF_PORT_DATA:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_PIN_N){1'b0}}, portData};
        end
        `ACMP_OFF_PORT_CTRL:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_PIN_N){1'b0}}, portCtrl};
        end
        `ACMP_OFF_PIN_FUNC:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_PIN_N){1'b0}}, pinFunc};
        end
        `ACMP_OFF_PORT_READ:
        begin
            next_regRdata = {{(`ACMP_DATA_W-`ACMP_PIN_N){1'b0}}, portRead}; // RULE11
        end
        default:
        begin
            next_regRdata = 8'h00;
        end
    endcase
end

// Data valid only in the cycle after the read strobe
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        regRdata <= 8'h00;
    end
    else if (regRd)
    begin
        regRdata <= next_regRdata;
    end
    else
    begin
        regRdata <= 8'h00;
    end
end

endmodule // acmp_ctrl

`default_nettype wire

// [inc/acmp_regs.vh]
// Register offsets, field positions and reset values of the comparator control block
`ifndef ACMP_REGS_VH
`define ACMP_REGS_VH

`define ACMP_ADDR_W 8
`define ACMP_DATA_W 8
`define ACMP_PIN_N 3

`define ACMP_OFF_CTRL 8'h00
`define ACMP_OFF_INT_STATUS 8'h01
`define ACMP_OFF_INT_MASK 8'h02
`define ACMP_OFF_INT_SET 8'h03
`define ACMP_OFF_PORT_DATA 8'h04
`define ACMP_OFF_PORT_CTRL 8'h05
`define ACMP_OFF_PIN_FUNC 8'h06
`define ACMP_OFF_PORT_READ 8'h07

`define ACMP_BIT_ON 6
`define ACMP_BIT_INVERT 5
`define ACMP_BIT_RESULT 4
`define ACMP_BIT_HYST 0

`define ACMP_CTRL_WR_MASK 8'h61
`define ACMP_RST_ON 1'b0
`define ACMP_RST_INVERT 1'b0
`define ACMP_RST_RESULT 1'b0
`define ACMP_RST_HYST 1'b1

`define ACMP_INT_CHANGE 0
`define ACMP_INT_WAKE 1
`define ACMP_INT_N 2
`define ACMP_RST_INT 2'h0

`define ACMP_PIN_POS 0
`define ACMP_PIN_NEG 1
`define ACMP_PIN_OUT 2
`define ACMP_RST_PINS 3'h0

`endif

// [core/acmp_sync.v]
// Two-stage synchroniser for the asynchronous comparator result
`timescale 1ns/1ns
`default_nettype none

module acmp_sync
(
    input wire mclk,
    input wire rstn,
    input wire asyncIn,
    output reg syncOut
);

reg stageOne;

// First stage feeds only the second one
always @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        stageOne <= 1'b0;
        syncOut <= 1'b0;
    end
    else
    begin
        stageOne <= asyncIn;
        syncOut <= stageOne;
    end
end

endmodule // acmp_sync

`default_nettype wire

// [verification/acmp_ctrl_props.sv]
// Port-level assertions for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module acmp_ctrl_props
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic cmpRaw,
    input wire logic cmpPower,
    input wire logic hystEnable,
    input wire logic lowPower,
    input wire logic wakeReq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_on; regWr && regAddr == 8'h00 |=> cmpPower == $past(regWdata[6]); endproperty
    a_on: assert property (p_on)
        else $error("enable bit not taken from write");
    property p_hyst; regWr && regAddr == 8'h00 |=> hystEnable == $past(regWdata[0]); endproperty
    a_hyst: assert property (p_hyst)
        else $error("hysteresis bit not taken from write");
    property p_hold; !(regWr && regAddr == 8'h00) |=> $stable(cmpPower) && $stable(hystEnable);
    endproperty
    a_hold: assert property (p_hold)
        else $error("control bits moved without a write");
    property p_rsvd; regRd && regAddr == 8'h00 |=> regRdata[7] == 1'b0 && regRdata[3:1] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("unused control bits read nonzero");
    property p_unmap; regRd && regAddr > 8'h07 |=> regRdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped address read nonzero");
    // Three cycles off, since the result register lags the enable by one
    property p_off; regRd && regAddr == 8'h00 && !cmpPower && !$past(cmpPower)
        && !$past(cmpPower, 2) |=> !regRdata[4]; endproperty
    a_off: assert property (p_off)
        else $error("output bit high while comparator off");
    // Only a control write can move polarity, so other writes may share the window
    property p_res; ($stable(cmpRaw) && cmpPower && !(regWr && regAddr == 8'h00))[*4]
        ##0 (regRd && regAddr == 8'h00)
        |=> regRdata[4] == ($past(cmpRaw, 2) ^ regRdata[5]); endproperty
    a_res: assert property (p_res)
        else $error("output bit disagrees with inputs and polarity");
    property p_wake; wakeReq |-> $past(lowPower) && $past(cmpPower); endproperty
    a_wake: assert property (p_wake)
        else $error("wake request outside low power or while off");
endmodule // acmp_ctrl_props
bind acmp_ctrl acmp_ctrl_props u_props (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .cmpRaw, .cmpPower, .hystEnable, .lowPower, .wakeReq);
`default_nettype wire

// [verification/acmp_analog_src.sv]
// Analog source standing at the comparator's plus and minus pins
`timescale 1ns/1ns
`default_nettype none
module acmp_analog_src
(
    input wire logic [7:0] vPos,
    input wire logic [7:0] vNeg,
    output logic cmpRaw
);
    // Settles off the clock grid, as a real comparator would
    always @(vPos or vNeg)
        cmpRaw <= #1 (vPos > vNeg);
endmodule // acmp_analog_src
`default_nettype wire

// [verification/analog_comparator_control_tb_top.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
`include "acmp_regs.vh"
module analog_comparator_control_tb_top;
    logic mclk, rstn, regWr, regRd, lowPower, cmpRaw, cmpPower, hystEnable, irq, wakeReq;
    logic [7:0] regAddr, regWdata, regRdata, vPos, vNeg, d;
    logic [2:0] pinIn, pinOut, pinOe;
    int mismatches, check_count, on, inv, mid, res, flag, seen;
    acmp_ctrl u_dut (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cmpRaw,
        .cmpPower, .hystEnable, .lowPower, .irq, .wakeReq, .pinIn, .pinOut, .pinOe);
    acmp_analog_src u_src (.vPos, .vNeg, .cmpRaw);
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    // Bounded look for a wake pulse
    task watch(output int s);
        s = 0;
        repeat (10)
        begin
            @(posedge mclk);
            #1 if (wakeReq === 1'b1) s = 1;
        end
    endtask
    task close_out;
        $display("mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        {rstn, regWr, regRd, lowPower, regAddr, regWdata, vPos, pinIn} = '0;
        vNeg = 8'hFF;
        seen = $urandom(32'h7F07);
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd(`ACMP_OFF_CTRL, 8'h01);
        chk(8'(hystEnable), 8'h01);
        chk(8'(cmpPower), 8'h00);
        wr(`ACMP_OFF_INT_MASK, 8'h01);
        // Inputs and control move apart, so each may flip the output once
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk);
            vPos <= 8'($urandom);
            vNeg <= 8'($urandom);
            repeat (4) @(posedge mclk);
            mid = on & ((vPos > vNeg) ^ inv);
            flag = (mid != res);
            d = 8'($urandom);
            on = d[6];
            inv = d[5];
            wr(`ACMP_OFF_CTRL, d);
            res = on & ((vPos > vNeg) ^ inv);
            flag = flag | (res != mid);
            rd(`ACMP_OFF_CTRL, (d & 8'h61) | 8'(res << 4));
            chk(8'(cmpPower), 8'(on));
            chk(8'(hystEnable), 8'(d[0]));
            rd(`ACMP_OFF_INT_STATUS, 8'(flag));
            chk(8'(irq), 8'(flag));
            wr(`ACMP_OFF_INT_STATUS, 8'h01);
            // Settled read with no control write nearby, in both polarities
            rd(`ACMP_OFF_CTRL, (d & 8'h61) | 8'(res << 4));
        end
        wr(`ACMP_OFF_CTRL, 8'h40);
        vPos <= 8'h10;
        vNeg <= 8'h20;
        repeat (5) @(posedge mclk);
        wr(`ACMP_OFF_INT_STATUS, 8'h03);
        lowPower <= 1'b1;
        vPos <= 8'h30;
        watch(seen);
        chk(8'(seen), 8'h01);
        rd(`ACMP_OFF_INT_STATUS, 8'h03);
        wr(`ACMP_OFF_INT_STATUS, 8'h03);
        wr(`ACMP_OFF_INT_SET, 8'h01);
        vPos <= 8'h10;
        watch(seen);
        chk(8'(seen), 8'h00);
        wr(`ACMP_OFF_CTRL, 8'h00);
        lowPower <= 1'b0;
        vPos <= 8'h30;
        wr(`ACMP_OFF_CTRL, 8'h40);
        wr(`ACMP_OFF_PORT_DATA, 8'h05);
        wr(`ACMP_OFF_PORT_CTRL, 8'h03);
        wr(`ACMP_OFF_PIN_FUNC, 8'h07);
        rd(`ACMP_OFF_PORT_READ, 8'h04);
        chk({5'h00, pinOe}, 8'h04);
        chk(8'(pinOut[2]), 8'h01);
        @(posedge mclk);
        pinIn <= 3'b010;
        wr(`ACMP_OFF_PIN_FUNC, 8'h00);
        rd(`ACMP_OFF_PORT_READ, 8'h06);
        chk({5'h00, pinOut}, 8'h05);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        rd(`ACMP_OFF_CTRL, 8'h50);
        close_out();
    end
endmodule // analog_comparator_control_tb_top
`default_nettype wire
